/* hw/htxint_defines.svh */
// Register offsets, field positions and reset values of the transmitter interrupt unit.
`ifndef HTXINT_DEFINES_SVH
`define HTXINT_DEFINES_SVH
`define HTXINT_OFS_ENABLE 8'h3C
`define HTXINT_OFS_STATUS 8'h3D
`define HTXINT_OFS_SEC_STATUS 8'h3E
`define HTXINT_OFS_SEC_ENABLE 8'h3F
`define HTXINT_RESET_BYTE 8'h00
`define HTXINT_BIT_HOTPLUG 0
`define HTXINT_BIT_RXPRES 1
`define HTXINT_BIT_HPLEVEL 2
`define HTXINT_BIT_AUXSEL 3
`define HTXINT_BIT_AUDIO 4
`define HTXINT_BIT_SECURITY 5
`define HTXINT_BIT_VREADY 6
`define HTXINT_BIT_AUTH 7
`define HTXINT_BIT_LINKSTABLE 0
`define HTXINT_BIT_KSVFIRST 1
`define HTXINT_EN_MASK 8'hFB
`define HTXINT_ST_CLEAR_MASK 8'hF3
`define HTXINT_SEC_MASK 8'h03
`endif

/* hw/htxint_pkg.sv */
// Types shared by the transmitter interrupt unit.
package htxint_pkg;
    typedef logic [7:0] htxint_byte_t;
endpackage

/* hw/htxint_sync.sv */
// Two-flop synchroniser bank for pin-level inputs.
`timescale 1ns/10ps
`default_nettype none
module htxint_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    initial begin
        if (WIDTH < 1) begin
            $error("htxint_sync width must be positive");
        end
    end

    // The first stage feeds only the second, to settle metastability.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule
`default_nettype wire

/* hw/htxint_edge.sv */
// Change detector: one-cycle pulse per bit whenever a level changes.
`timescale 1ns/10ps
`default_nettype none
module htxint_edge #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] changed
);
    logic [WIDTH-1:0] prevLevel;
    logic primed;

    initial begin
        if (WIDTH < 1) begin
            $error("htxint_edge width must be positive");
        end
    end

    // Remember last level; the first cycle after reset only primes it.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prevLevel <= '0;
            primed <= 1'b0;
        end else begin
            prevLevel <= level;
            primed <= 1'b1;
        end
    end

    // No pulse before priming, so a level present at reset is not an event.
    assign changed = primed ? (level ^ prevLevel) : '0;
endmodule
`default_nettype wire

/* hw/htxint_unit.sv */
// Interrupt enable and status registers of the transmitter programming interface.
//
// Contract
// R1 - Writing 1 to an enable bit enables the source and clears its pending flag.
// R2 - Writing 0 to an enable bit disables it and keeps any pending flag.
// R3 - Hot-plug events keep raising the interrupt in the low-power state.
// R4 - Status flags record events whether or not the source is enabled.
// R5 - Writing 1 to a status bit clears it; bits written 0 stay.
// R6 - Status bits 3 and 2 are live read-only state; writes do nothing.
// R7 - Enables: 7 auth, 6 V ready, 5 security, 4 audio, 3 aux select, 1-0 events.
// R8 - Status bits 7..4 pending, 3 presence/aux, 2 hot-plug level, 1..0 pending.
// R9 - Hot-plug level follows the sink line; any change flags an event.
// R10 - Receiver presence state shown; every change flags an event.
// R11 - With enable bit 3 set, status bit 3 shows the aux port pending state.
// R12 - Writing 1 to status bit 3 has no effect; aux clears at its own port.
// R13 - Aux port interrupt follows its own enables, not the select bit.
// R14 - Audio error flagged when the S/PDIF stream event is handled automatically.
// R15 - Conditions on the I2S audio path never flag audio errors.
// R16 - Any change of the two-bit link status field flags a security event.
// R17 - V ready flagged when the availability bit rises after selection.
// R18 - Any change of the two-bit authentication field flags an auth event.
// R19 - Each register is one whole byte access.
// R20 - Link-stable event is secondary status bit 0 with enable bit 0.
// R21 - Interrupt output high while any enabled clearable flag is pending.
`timescale 1ns/10ps
`default_nettype none
`include "htxint_defines.svh"
module htxint_unit (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire htxint_pkg::htxint_byte_t regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output htxint_pkg::htxint_byte_t regRdData,
    input wire logic hotPlugDetectLine,
    input wire logic receiverPresence,
    input wire logic auxPortPending,
    input wire logic auxPortIrq,
    input wire logic spdifEventHandled,
    input wire logic i2sSelected,
    input wire logic [1:0] linkStatus,
    input wire logic [1:0] authStatus,
    input wire logic vValueAvailable,
    input wire logic ksvFirstByte,
    input wire logic linkStable,
    input wire logic lowPowerState,
    output logic hostIrq
);
    import htxint_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and event detection.

    logic [1:0] pinSync;
    logic hotPlugLevel;
    logic presenceLevel;
    logic [1:0] pinChanged;
    logic [3:0] fieldChanged;
    logic vPrev;
    logic ksvPrev;
    logic stablePrev;
    logic eventVReady;
    logic eventKsv;
    logic eventStable;
    logic eventAudio;

    // The sink line and receiver sense come from pins and must be retimed.
    htxint_sync #(.WIDTH(2)) u_pinSync (
        .mclk(mclk),
        .rst(rst),
        .asyncIn({receiverPresence, hotPlugDetectLine}),
        .syncOut(pinSync)
    );
    assign hotPlugLevel = pinSync[0]; // R9
    assign presenceLevel = pinSync[1]; // R10

    // Any change of either level is an event.
    htxint_edge #(.WIDTH(2)) u_pinEdge (
        .mclk(mclk),
        .rst(rst),
        .level(pinSync),
        .changed(pinChanged)
    );

    // Status fields of the security engine are on this clock already.
    htxint_edge #(.WIDTH(4)) u_fieldEdge (
        .mclk(mclk),
        .rst(rst),
        .level({authStatus, linkStatus}),
        .changed(fieldChanged)
    );

    // Rising-edge history for availability, first key byte and link stable.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vPrev <= 1'b0;
            ksvPrev <= 1'b0;
            stablePrev <= 1'b0;
        end else begin
            vPrev <= vValueAvailable;
            ksvPrev <= ksvFirstByte;
            stablePrev <= linkStable;
        end
    end
    assign eventVReady = vValueAvailable & ~vPrev; // R17
    assign eventKsv = ksvFirstByte & ~ksvPrev;
    assign eventStable = linkStable & ~stablePrev; // R20
    // Audio errors only from the S/PDIF path; I2S input masks them.
    assign eventAudio = spdifEventHandled & ~i2sSelected; // R14 R15

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.

    logic selEnable;
    logic selStatus;
    logic selSecStatus;
    logic selSecEnable;
    assign selEnable = (regAddr == `HTXINT_OFS_ENABLE);
    assign selStatus = (regAddr == `HTXINT_OFS_STATUS);
    assign selSecStatus = (regAddr == `HTXINT_OFS_SEC_STATUS);
    assign selSecEnable = (regAddr == `HTXINT_OFS_SEC_ENABLE);

    // Every access carries a full byte; there are no partial lanes.
    logic wrEnable;
    logic wrStatus;
    logic wrSecStatus;
    logic wrSecEnable;
    assign wrEnable = regWrite & selEnable; // R19
    assign wrStatus = regWrite & selStatus; // R19
    assign wrSecStatus = regWrite & selSecStatus;
    assign wrSecEnable = regWrite & selSecEnable;

    ////////////////////////////////////////////////////////////////////////////
    // Enable and pending storage.

    htxint_byte_t intEnable;
    htxint_byte_t secEnable;
    htxint_byte_t pending;
    htxint_byte_t secPending;
    htxint_byte_t setMain;
    htxint_byte_t setSec;
    htxint_byte_t clrMain;
    htxint_byte_t clrSec;
    htxint_byte_t next_pending;
    htxint_byte_t next_secPending;

    // Event sets are independent of the enables, so polling works.
    assign setMain = {fieldChanged[3] | fieldChanged[2], eventVReady,
                      fieldChanged[1] | fieldChanged[0], eventAudio,
                      2'b00, pinChanged[1], pinChanged[0]}; // R4 R16 R18
    assign setSec = {6'b00_0000, eventKsv, eventStable};

    // Clears from status writes of 1, and from writing 1 to an enable bit.
    assign clrMain = ((wrStatus ? regWrData : 8'h00) |
                      (wrEnable ? regWrData : 8'h00)) & `HTXINT_ST_CLEAR_MASK; // R1 R5 R6 R12
    assign clrSec = ((wrSecStatus ? regWrData : 8'h00) |
                     (wrSecEnable ? regWrData : 8'h00)) & `HTXINT_SEC_MASK;

    // A set in the same cycle as its clear wins, so no event is lost.
    assign next_pending = ((pending & ~clrMain) | setMain) & `HTXINT_ST_CLEAR_MASK;
    assign next_secPending = ((secPending & ~clrSec) | setSec) & `HTXINT_SEC_MASK;

    // Enables store the written byte under their masks (main drops bit 2, secondary keeps 1..0); a 0 leaves pending alone.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            intEnable <= `HTXINT_RESET_BYTE;
            secEnable <= `HTXINT_RESET_BYTE;
        end else begin
            if (wrEnable) begin
                intEnable <= regWrData & `HTXINT_EN_MASK; // R1 R2 R7
            end
            if (wrSecEnable) begin
                secEnable <= regWrData & `HTXINT_SEC_MASK; // R20
            end
        end
    end

    // Pending flags.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending <= `HTXINT_RESET_BYTE;
            secPending <= `HTXINT_RESET_BYTE;
        end else begin
            pending <= next_pending;
            secPending <= next_secPending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path and interrupt.

    htxint_byte_t statusView;
    htxint_byte_t next_regRdData;
    logic bit3View;

    // Bit 3 is a view: aux pending when selected, else receiver presence.
    assign bit3View = intEnable[`HTXINT_BIT_AUXSEL] ? auxPortPending : presenceLevel; // R11
    assign statusView = {pending[7:4], bit3View, hotPlugLevel, pending[1:0]}; // R8

    // Unmapped offsets read as zero.
    assign next_regRdData = selEnable ? intEnable :
                            selStatus ? statusView :
                            selSecStatus ? secPending :
                            selSecEnable ? secEnable : 8'h00;

    // Read data is registered when the read is taken.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdData <= `HTXINT_RESET_BYTE;
        end else if (regRead) begin
            regRdData <= next_regRdData;
        end
    end

    // The aux port raises its own interrupt regardless of the select bit.
    // Low-power state has no gating here, so hot-plug still interrupts.
    assign hostIrq = (|(pending & intEnable & `HTXINT_ST_CLEAR_MASK)) |
                     (|(secPending & secEnable)) | auxPortIrq; // R3 R13 R21

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_enable_clears;
        @(posedge mclk) disable iff (rst)
        (wrEnable && regWrData[0] && !setMain[0]) |=> !pending[0];
    endproperty
    a_enable_clears: assert property (p_enable_clears) else $error("enable write left pending"); // R1

    property p_zero_keeps;
        @(posedge mclk) disable iff (rst)
        (wrEnable && !regWrData[5] && !wrStatus && pending[5]) |=> pending[5];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("disable cleared pending"); // R2

    property p_lowpower_irq;
        @(posedge mclk) disable iff (rst)
        (lowPowerState && pending[0] && intEnable[0]) |-> hostIrq;
    endproperty
    a_lowpower_irq: assert property (p_lowpower_irq) else $error("hot-plug irq lost"); // R3

    property p_poll_disabled;
        @(posedge mclk) disable iff (rst)
        (pinChanged[0] && !intEnable[0]) |=> pending[0];
    endproperty
    a_poll_disabled: assert property (p_poll_disabled) else $error("disabled event not recorded"); // R4

    property p_clear_selective;
        @(posedge mclk) disable iff (rst)
        wrStatus |=> (($past(pending) & ~$past(regWrData) & ~pending) == 8'h00);
    endproperty
    a_clear_selective: assert property (p_clear_selective) else $error("unwritten bit cleared"); // R5

    property p_live_bits;
        @(posedge mclk) disable iff (rst)
        wrStatus |=> (pending[3:2] == 2'h0) && (statusView[2] == hotPlugLevel);
    endproperty
    a_live_bits: assert property (p_live_bits) else $error("bit 2 not live level"); // R6

    property p_aux_view;
        @(posedge mclk) disable iff (rst)
        intEnable[3] |-> statusView[3] == auxPortPending;
    endproperty
    a_aux_view: assert property (p_aux_view) else $error("aux view wrong"); // R11

    property p_security_change;
        @(posedge mclk) disable iff (rst)
        ($changed(linkStatus) && !$past(rst) && !wrStatus && !wrEnable) |=> pending[5];
    endproperty
    a_security_change: assert property (p_security_change) else $error("link change missed"); // R16

    property p_i2s_quiet;
        @(posedge mclk) disable iff (rst)
        (i2sSelected && !pending[4]) |=> !pending[4];
    endproperty
    a_i2s_quiet: assert property (p_i2s_quiet) else $error("I2S flagged audio error"); // R15

    property p_irq_idle;
        @(posedge mclk) disable iff (rst)
        (!auxPortIrq && (pending & intEnable) == 8'h00 && (secPending & secEnable) == 8'h00)
            |-> !hostIrq;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("spurious irq"); // R21

    // The first edge after reset only primes the detectors, hence the reset guard.
    property p_presence_event;
        @(posedge mclk) disable iff (rst)
        ($changed(presenceLevel) && !$past(rst)) |=> pending[1];
    endproperty
    a_presence_event: assert property (p_presence_event) else $error("presence change missed"); // R10

    property p_aux_irq;
        @(posedge mclk) disable iff (rst)
        auxPortIrq |-> hostIrq;
    endproperty
    a_aux_irq: assert property (p_aux_irq) else $error("aux irq blocked"); // R13

    property p_vready;
        @(posedge mclk) disable iff (rst)
        ($rose(vValueAvailable) && !$past(rst)) |=> pending[6];
    endproperty
    a_vready: assert property (p_vready) else $error("V ready missed"); // R17

    property p_auth_change;
        @(posedge mclk) disable iff (rst)
        ($changed(authStatus) && !$past(rst)) |=> pending[7];
    endproperty
    a_auth_change: assert property (p_auth_change) else $error("auth change missed"); // R18
endmodule
`default_nettype wire

/* verif/htxint_host.sv */
// Host model that reaches the interrupt registers one whole byte at a time.
`timescale 1ns/10ps
`default_nettype none
module htxint_host (
    input wire logic mclk,
    output logic [7:0] regAddr,
    output htxint_pkg::htxint_byte_t regWrData,
    output logic regWrite,
    output logic regRead,
    input wire htxint_pkg::htxint_byte_t regRdData
);
    import htxint_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // The bus starts idle with no strobe raised.
    initial begin
        regAddr = 8'h00;
        regWrData = 8'hFF;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // A write is one byte; status bits other than 3 and 2 are cleared by writing them as 1, or by writing 1 to the matching enable bit.
    // Released data shows the inverse so a stale byte is never mistaken for a live one.
    task automatic wr(input logic [7:0] addr, input htxint_byte_t data);
        @(posedge mclk);
        #1;
        regAddr = addr;
        regWrData = data;
        regWrite = 1'b1;
        @(posedge mclk);
        #1;
        regWrite = 1'b0;
        regWrData = ~data;
    endtask
    // A read is one byte, taken on the edge and returned just after it.
    task automatic rd(input logic [7:0] addr, output htxint_byte_t data);
        @(posedge mclk);
        #1;
        regAddr = addr;
        regRead = 1'b1;
        @(posedge mclk);
        #1;
        regRead = 1'b0;
        data = regRdData;
    endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the transmitter interrupt unit.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import htxint_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr;
    htxint_byte_t regWrData;
    logic regWrite;
    logic regRead;
    htxint_byte_t regRdData;
    logic hotPlug = 1'b0;
    logic presence = 1'b0;
    logic auxPend = 1'b0;
    logic auxIrq = 1'b0;
    logic spdif = 1'b0;
    logic i2s = 1'b0;
    logic [1:0] linkSt = 2'b00;
    logic [1:0] authSt = 2'b00;
    logic vAvail = 1'b0;
    logic key_selection_vector = 1'b0;
    logic stable = 1'b0;
    logic lowPower = 1'b0;
    logic hostIrq;
    int nErrors = 0;
    int nCompared = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Design and host model.
    htxint_unit htxint_unit_inst (.mclk(mclk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .hotPlugDetectLine(hotPlug), .receiverPresence(presence),
        .auxPortPending(auxPend), .auxPortIrq(auxIrq), .spdifEventHandled(spdif),
        .i2sSelected(i2s), .linkStatus(linkSt), .authStatus(authSt),
        .vValueAvailable(vAvail), .ksvFirstByte(key_selection_vector), .linkStable(stable),
        .lowPowerState(lowPower), .hostIrq(hostIrq));
    htxint_host htxint_host_inst (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
    // Clock of 100 ns.
    always #50 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers; every wait is a fixed count, so the run cannot hang.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chkByte(input htxint_byte_t got, input htxint_byte_t exp);
        nCompared++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chkByte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [7:0] a, input htxint_byte_t d);
        htxint_host_inst.wr(a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input htxint_byte_t exp);
        htxint_byte_t got;
        htxint_host_inst.rd(a, got);
        chkByte(got, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, and an unmapped offset reads as zero.
    task automatic testReset();
        rdc(8'h3C, 8'h00);
        rdc(8'h3D, 8'h00);
        rdc(8'h3E, 8'h00);
        rdc(8'h3F, 8'h00);
        rdc(8'h40, 8'h00);
        chkBit(hostIrq, 1'b0);
        $display("testReset done");
    endtask
    // Hot-plug events flag while disabled, and still interrupt in low power.
    task automatic testHotPlug();
        lowPower = 1'b1;
        hotPlug = 1'b1;
        cyc(4);
        rdc(8'h3D, 8'h05);
        chkBit(hostIrq, 1'b0);
        wr(8'h3C, 8'h01);
        rdc(8'h3D, 8'h04);
        hotPlug = 1'b0;
        cyc(4);
        chkBit(hostIrq, 1'b1);
        hotPlug = 1'b1;
        cyc(4);
        wr(8'h3D, 8'h0C);
        rdc(8'h3D, 8'h05);
        wr(8'h3D, 8'h01);
        rdc(8'h3D, 8'h04);
        cyc(1);
        chkBit(hostIrq, 1'b0);
        wr(8'h3C, 8'h00);
        $display("testHotPlug done");
    endtask
    // Receiver presence shows as a level and as an event.
    task automatic testPresence();
        presence = 1'b1;
        cyc(4);
        rdc(8'h3D, 8'h0E);
        wr(8'h3D, 8'h02);
        rdc(8'h3D, 8'h0C);
        $display("testPresence done");
    endtask
    // Auxiliary port reflection only changes what bit 3 shows.
    task automatic testAux();
        auxPend = 1'b1;
        presence = 1'b0;
        wr(8'h3C, 8'h08);
        cyc(4);
        rdc(8'h3D, 8'h0E);
        wr(8'h3D, 8'h08);
        rdc(8'h3D, 8'h0E);
        auxIrq = 1'b1;
        wr(8'h3C, 8'h00);
        cyc(1);
        chkBit(hostIrq, 1'b1);
        rdc(8'h3D, 8'h06);
        auxIrq = 1'b0;
        cyc(1);
        chkBit(hostIrq, 1'b0);
        wr(8'h3D, 8'h02);
        rdc(8'h3D, 8'h04);
        $display("testAux done");
    endtask
    // Audio, security, V ready and authentication events, and enable side effects.
    task automatic testFields();
        spdif = 1'b1;
        cyc(1);
        spdif = 1'b0;
        linkSt = 2'b01;
        authSt = 2'b10;
        vAvail = 1'b1;
        cyc(4);
        rdc(8'h3D, 8'hF4);
        chkBit(hostIrq, 1'b0);
        wr(8'h3C, 8'hFF);
        rdc(8'h3C, 8'hFB);
        rdc(8'h3D, 8'h0C);
        i2s = 1'b1;
        spdif = 1'b1;
        cyc(1);
        spdif = 1'b0;
        cyc(4);
        rdc(8'h3D, 8'h0C);
        linkSt = 2'b11;
        cyc(4);
        chkBit(hostIrq, 1'b1);
        wr(8'h3C, 8'h00);
        rdc(8'h3D, 8'h24);
        chkBit(hostIrq, 1'b0);
        wr(8'h3D, 8'hFF);
        rdc(8'h3D, 8'h04);
        $display("testFields done");
    endtask
    // Secondary pair: link stable and first key selection vector byte.
    task automatic testSecondary();
        stable = 1'b1;
        key_selection_vector = 1'b1;
        cyc(4);
        rdc(8'h3E, 8'h03);
        chkBit(hostIrq, 1'b0);
        wr(8'h3F, 8'hFF);
        rdc(8'h3F, 8'h03);
        rdc(8'h3E, 8'h00);
        stable = 1'b0;
        cyc(2);
        stable = 1'b1;
        cyc(4);
        chkBit(hostIrq, 1'b1);
        wr(8'h3E, 8'h01);
        rdc(8'h3E, 8'h00);
        chkBit(hostIrq, 1'b0);
        wr(8'h40, 8'hFF);
        rdc(8'h40, 8'h00);
        $display("testSecondary done");
    endtask
    // Verdict and end of run.
    task automatic completeRun();
        $display("Comparisons %0d, mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence: reset for six cycles, then each scenario in turn.
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rst = 1'b0;
        testReset();
        testHotPlug();
        testPresence();
        testAux();
        testFields();
        testSecondary();
        completeRun();
    end
endmodule
`default_nettype wire
